// ### common/timer_defs.svh
// offsets, field positions, reset values and codes of the timer pair
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define TMR0_COUNT_IDX        14'hF00
`define TMR0_CMP_HIGH_IDX     14'hF04
`define TMR0_CMP_LOW_IDX      14'hF05
`define TMR0_CASC_CTRL_IDX    14'hF06
`define TMR0_MAIN_CTRL_IDX    14'hF07
`define TMR1_COUNT_IDX        14'hF08
`define TMR1_CMP_HIGH_IDX     14'hF0C
`define TMR1_CMP_LOW_IDX      14'hF0D
`define TMR1_CASC_CTRL_IDX    14'hF0E
`define TMR1_MAIN_CTRL_IDX    14'hF0F
// index bits that pick the timer, and the register within a timer
`define TMR_SEL_BIT           3
`define TMR_BASE_IDX          10'h0F0
`define TMR_SUB_COUNT         3'h0
`define TMR_SUB_CMP_HIGH      3'h4
`define TMR_SUB_CMP_LOW       3'h5
`define TMR_SUB_CASC          3'h6
`define TMR_SUB_MAIN          3'h7

// ==========================================================
// field positions
`define CTRL_ENABLE_BIT       7
`define CTRL_POLARITY_BIT     6
`define CTRL_PRESCALE_HI      5
`define CTRL_PRESCALE_LO      3
`define CTRL_MODE_HI          2
`define CTRL_MODE_LO          0
`define CASC_BIT              4

// ==========================================================
// reset values and constants
`define CTRL_RESET            8'h00
`define CMP_RESET             8'h00
`define CASC_RESET            8'h00
`define COUNT_RESET           16'h0000
`define COUNT_LAST            16'hFFFF
`define PRESCALE_FULL         7'h7F
`define AXI_RESP_OKAY         2'h0
`define AXI_RESP_SLVERR       2'h2

`endif

// ### common/timer_pkg.sv
// types shared by the timer pair
`default_nettype none
package timer_pkg;

	// ======================================================
	// operating modes of one timer
	typedef enum logic [2:0] {
		MODE_ONE_SHOT   = 3'h0,
		MODE_CONTINUOUS = 3'h1,
		MODE_COUNTER    = 3'h2,
		MODE_PWM        = 3'h3,
		MODE_CAPTURE    = 3'h4,
		MODE_CAP_CMP    = 3'h5
	} op_mode_t;

endpackage : timer_pkg
`default_nettype wire

// ### logic/timer_pwm_capture_core.sv
// two 16-bit timers with pwm, capture and cascade behind axi4-lite
// Summary of operation
// R1 - count equal to compare bytes changes output; the code does this only in pwm and capture/compare modes
// R2 - capture modes store count into compare bytes
// R3 - cascade bit swaps inputs to partner outputs
// R4 - count holds while disabled, counts while enabled
// R5 - one-shot/continuous: idle polarity, toggle on reload
// R6 - counter mode toggles; polarity picks counted edge
// R7 - pwm polarity 0: idle low, match high
// R8 - pwm polarity 1: idle high, match low
// R9 - capture polarity picks rising or falling edge
// R10 - main control holds all fields, resets zero; the code keeps the cascade bit in the separate cascade control register
// R11 - power-of-two prescaler and six operating modes
//
// Register access over AXI4-Lite was left to the implementer.
`default_nettype none
`include "timer_defs.svh"

module timer_pwm_capture_core import timer_pkg::*; #(
	parameter int NUM_TIMERS  = 2,
	parameter int COUNT_WIDTH = 16,
	parameter int ADDR_WIDTH  = 16
) (
	// clock and reset
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	// axi4-lite write address
	input  wire logic [ADDR_WIDTH-1:0]   s_axi_awaddr,
	input  wire logic [2:0]              s_axi_awprot,
	input  wire logic                    s_axi_awvalid,
	output var  logic                    s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output var  logic                    s_axi_wready,
	// axi4-lite write response
	output var  logic [1:0]              s_axi_bresp,
	output var  logic                    s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	// axi4-lite read address
	input  wire logic [ADDR_WIDTH-1:0]   s_axi_araddr,
	input  wire logic [2:0]              s_axi_arprot,
	input  wire logic                    s_axi_arvalid,
	output var  logic                    s_axi_arready,
	// axi4-lite read data
	output var  logic [31:0]             s_axi_rdata,
	output var  logic [1:0]              s_axi_rresp,
	output var  logic                    s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	// timer pins
	input  wire logic [NUM_TIMERS-1:0]   timer_in,
	output var  logic [NUM_TIMERS-1:0]   timer_out
);

	// ======================================================
	// elaboration checks
	if (NUM_TIMERS != 2) begin : g_bad_timers
		$error("cascade pairing needs exactly two timers");
	end
	if (COUNT_WIDTH != 16) begin : g_bad_width
		$error("count must be two compare bytes wide");
	end
	if (ADDR_WIDTH < 16) begin : g_bad_addr
		$error("address too narrow for the register map");
	end

	// ======================================================
	// register storage
	logic [7:0]             cmp_high [NUM_TIMERS]; // compare high byte
	logic [7:0]             cmp_low  [NUM_TIMERS]; // compare low byte
	logic [7:0]             casc_ctl [NUM_TIMERS]; // cascade control
	logic [7:0]             main_ctl [NUM_TIMERS]; // main control
	logic [COUNT_WIDTH-1:0] count    [NUM_TIMERS]; // live count
	logic [6:0]             pre      [NUM_TIMERS]; // prescale counter
	logic [NUM_TIMERS-1:0]  in_prev;               // last selected input

	// bus bookkeeping
	logic [ADDR_WIDTH-1:0]  aw_addr;   // held write address
	logic [31:0]            w_data;    // held write data
	logic [3:0]             w_strb;    // held write strobes
	logic                   aw_got;    // address taken, awaiting data
	logic                   w_got;     // data taken, awaiting address

	// ======================================================
	// decode helpers
	// true when the address lands on a mapped register
	function automatic logic map_hit(input logic [ADDR_WIDTH-1:0] a);
		logic [13:0] idx;
		idx = a[15:2];
		map_hit = (idx[13:4] == `TMR_BASE_IDX) &&
			(idx[2:0] == `TMR_SUB_COUNT || idx[2] == 1'b1);
	endfunction : map_hit

	// low mask of prescale counter bits for a divide by 2^p
	function automatic logic [6:0] pre_mask(input logic [2:0] p);
		pre_mask = `PRESCALE_FULL >> (3'h7 - p);
	endfunction : pre_mask

	// ======================================================
	// per-timer combinational view
	logic                   en      [NUM_TIMERS]; // enable bit
	logic                   pol     [NUM_TIMERS]; // polarity bit
	op_mode_t               mode    [NUM_TIMERS]; // operating mode
	logic                   in_sel  [NUM_TIMERS]; // chosen input
	logic                   edge_hit[NUM_TIMERS]; // chosen edge seen
	logic                   step    [NUM_TIMERS]; // count advances
	logic                   match   [NUM_TIMERS]; // count equals compare
	logic                   reload  [NUM_TIMERS]; // count wraps
	logic                   capture [NUM_TIMERS]; // capture now
	logic [COUNT_WIDTH-1:0] cmp_val [NUM_TIMERS]; // joined compare

	always_comb begin
		for (int i = 0; i < NUM_TIMERS; i++) begin
			en[i]   = main_ctl[i][`CTRL_ENABLE_BIT];
			pol[i]  = main_ctl[i][`CTRL_POLARITY_BIT];
			mode[i] = op_mode_t'(main_ctl[i][`CTRL_MODE_HI:`CTRL_MODE_LO]);
			// R3 input selection
			in_sel[i] = casc_ctl[i][`CASC_BIT] ?
				timer_out[NUM_TIMERS-1-i] : timer_in[i];
			// R6 R9 polarity picks the edge
			edge_hit[i] = pol[i] ? (in_prev[i] & ~in_sel[i])
				: (~in_prev[i] & in_sel[i]);
			// R11 prescaled tick, counter mode counts edges
			step[i] = en[i] && ((mode[i] == MODE_COUNTER) ? edge_hit[i]
				: ((pre[i] & pre_mask(main_ctl[i][`CTRL_PRESCALE_HI:
				`CTRL_PRESCALE_LO])) == pre_mask(main_ctl[i]
				[`CTRL_PRESCALE_HI:`CTRL_PRESCALE_LO])));
			// R1 compare on joined bytes
			cmp_val[i] = {cmp_high[i], cmp_low[i]};
			match[i]   = en[i] && (count[i] == cmp_val[i]);
			reload[i]  = step[i] && ((count[i] == `COUNT_LAST) ||
				(mode[i] == MODE_CAP_CMP && match[i]));
			capture[i] = en[i] && edge_hit[i] &&
				(mode[i] == MODE_CAPTURE || mode[i] == MODE_CAP_CMP);
		end
	end

	// write strobe into the register file, one cycle per write
	logic                   do_write;
	logic [13:0]            w_idx;
	assign do_write = aw_got && w_got && !s_axi_bvalid;
	assign w_idx    = aw_addr[15:2];

	// ======================================================
	// axi write channels
	// address and data are taken in either order and held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			aw_got        <= 1'b0;
			w_got         <= 1'b0;
			aw_addr       <= '0;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr       <= s_axi_awaddr;
				aw_got        <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				w_got        <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			// both halves consumed by the write itself
			if (do_write) begin
				aw_got <= 1'b0;
				w_got  <= 1'b0;
			end
			// reopen only after the response is accepted
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// write response, error for holes in the map
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `AXI_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= map_hit(aw_addr) ? `AXI_RESP_OKAY
				: `AXI_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ======================================================
	// axi read channel, answer one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `AXI_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= map_hit(s_axi_araddr) ? `AXI_RESP_OKAY
				: `AXI_RESP_SLVERR;
			s_axi_rdata   <= 32'h0000_0000;
			if (map_hit(s_axi_araddr)) begin
				// narrow registers sit in the low bits
				unique case (s_axi_araddr[4:2])
					`TMR_SUB_COUNT: s_axi_rdata[15:0] <=
						count[s_axi_araddr[`TMR_SEL_BIT+2]];
					`TMR_SUB_CMP_HIGH: s_axi_rdata[7:0] <=
						cmp_high[s_axi_araddr[`TMR_SEL_BIT+2]];
					`TMR_SUB_CMP_LOW: s_axi_rdata[7:0] <=
						cmp_low[s_axi_araddr[`TMR_SEL_BIT+2]];
					`TMR_SUB_CASC: s_axi_rdata[7:0] <=
						casc_ctl[s_axi_araddr[`TMR_SEL_BIT+2]];
					`TMR_SUB_MAIN: s_axi_rdata[7:0] <=
						main_ctl[s_axi_araddr[`TMR_SEL_BIT+2]];
					default: s_axi_rdata <= 32'h0000_0000;
				endcase
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

	// ======================================================
	// control registers
	// one-shot drops its own enable on reload; a software write
	// in the same cycle wins so a fresh start is never lost
	always_ff @(posedge aclk) begin
		for (int i = 0; i < NUM_TIMERS; i++) begin
			// R10 fields reset to zero
			if (!aresetn) begin
				main_ctl[i] <= `CTRL_RESET;
				casc_ctl[i] <= `CASC_RESET;
			end else begin
				if (do_write && map_hit(aw_addr) && w_strb[0] &&
					w_idx[`TMR_SEL_BIT] == i[0]) begin
					if (w_idx[2:0] == `TMR_SUB_MAIN) begin
						main_ctl[i] <= w_data[7:0];
					end
					if (w_idx[2:0] == `TMR_SUB_CASC) begin
						casc_ctl[i] <= w_data[7:0];
					end
				end
				if (reload[i] && mode[i] == MODE_ONE_SHOT &&
					!(do_write && w_idx[2:0] == `TMR_SUB_MAIN &&
					w_idx[`TMR_SEL_BIT] == i[0])) begin
					main_ctl[i][`CTRL_ENABLE_BIT] <= 1'b0;
				end
			end
		end
	end

	// compare bytes; a capture beats a software write
	always_ff @(posedge aclk) begin
		for (int i = 0; i < NUM_TIMERS; i++) begin
			if (!aresetn) begin
				cmp_high[i] <= `CMP_RESET;
				cmp_low[i]  <= `CMP_RESET;
			end else if (capture[i]) begin
				// R2 captured count into compare bytes
				{cmp_high[i], cmp_low[i]} <= count[i];
			end else if (do_write && map_hit(aw_addr) && w_strb[0] &&
				w_idx[`TMR_SEL_BIT] == i[0]) begin
				if (w_idx[2:0] == `TMR_SUB_CMP_HIGH) begin
					cmp_high[i] <= w_data[7:0];
				end
				if (w_idx[2:0] == `TMR_SUB_CMP_LOW) begin
					cmp_low[i] <= w_data[7:0];
				end
			end
		end
	end

	// ======================================================
	// counting: prescaler, count and input history
	always_ff @(posedge aclk) begin
		for (int i = 0; i < NUM_TIMERS; i++) begin
			if (!aresetn) begin
				count[i]   <= `COUNT_RESET;
				pre[i]     <= 7'h00;
				in_prev[i] <= 1'b0;
			end else begin
				in_prev[i] <= in_sel[i];
				// R11 prescaler restarts while idle
				pre[i] <= en[i] ? pre[i] + 7'h01 : 7'h00;
				// R4 hold unless enabled and stepping
				if (reload[i]) begin
					count[i] <= `COUNT_RESET;
				end else if (step[i]) begin
					count[i] <= count[i] + 16'h0001;
				end
			end
		end
	end

	// ======================================================
	// output drive
	always_ff @(posedge aclk) begin
		for (int i = 0; i < NUM_TIMERS; i++) begin
			if (!aresetn) begin
				timer_out[i] <= 1'b0;
			end else if (!en[i]) begin
				// R5 R7 R8 idle level is the polarity bit
				timer_out[i] <= pol[i];
			end else if (mode[i] == MODE_PWM) begin
				// R7 R8 reload restores polarity, match inverts
				if (reload[i]) begin
					timer_out[i] <= pol[i];
				end else if (match[i]) begin
					timer_out[i] <= ~pol[i];
				end
			end else if (reload[i]) begin
				// R5 R6 toggle on every reload
				timer_out[i] <= ~timer_out[i];
			end
		end
	end

	// ======================================================
	// checks
	for (genvar g = 0; g < 2; g++) begin : g_chk
		a_hold_when_off: assert property ( // R4
			@(posedge aclk) disable iff (!aresetn)
			!en[g] |=> count[g] == $past(count[g]))
			else $error("count moved while disabled");
		a_pwm_idle_low: assert property ( // R7
			@(posedge aclk) disable iff (!aresetn)
			(mode[g] == MODE_PWM && !en[g] && !pol[g])
			|=> timer_out[g] == 1'b0)
			else $error("pwm idle output not low");
		a_pwm_idle_high: assert property ( // R8
			@(posedge aclk) disable iff (!aresetn)
			(mode[g] == MODE_PWM && !en[g] && pol[g])
			|=> timer_out[g] == 1'b1)
			else $error("pwm idle output not high");
		a_pwm_match_out: assert property ( // R1
			@(posedge aclk) disable iff (!aresetn)
			(mode[g] == MODE_PWM && match[g] && !reload[g])
			|=> timer_out[g] == !$past(pol[g]))
			else $error("pwm match did not drive output");
		a_capture_store: assert property ( // R2
			@(posedge aclk) disable iff (!aresetn)
			capture[g] |=> {cmp_high[g], cmp_low[g]} ==
			$past(count[g]))
			else $error("capture did not store count");
		a_reload_toggle: assert property ( // R5
			@(posedge aclk) disable iff (!aresetn)
			(en[g] && mode[g] == MODE_CONTINUOUS && reload[g])
			|=> timer_out[g] != $past(timer_out[g]))
			else $error("reload did not toggle output");
		a_counter_edge: assert property ( // R6
			@(posedge aclk) disable iff (!aresetn)
			(en[g] && mode[g] == MODE_COUNTER && !edge_hit[g])
			|=> count[g] == $past(count[g]))
			else $error("counter moved without an edge");
		a_cascade_source: assert property ( // R3
			@(posedge aclk) disable iff (!aresetn)
			casc_ctl[g][`CASC_BIT] |-> in_sel[g] == timer_out[1-g])
			else $error("cascade input not partner output");
		a_ctrl_reset: assert property ( // R10
			@(posedge aclk)
			!aresetn |=> main_ctl[g] == `CTRL_RESET)
			else $error("main control not cleared by reset");
		a_prescale_tick: assert property ( // R11
			@(posedge aclk) disable iff (!aresetn)
			(en[g] && mode[g] == MODE_CONTINUOUS &&
			main_ctl[g][`CTRL_PRESCALE_HI:`CTRL_PRESCALE_LO] == 3'h1
			&& pre[g][0] == 1'b0) |=> count[g] == $past(count[g]))
			else $error("count stepped off the prescale tick");
	end

endmodule : timer_pwm_capture_core
`default_nettype wire

// ### tb/timer_pin_model.sv
// far-side model that drives the two timer input pins
`default_nettype none
module timer_pin_model (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// pin levels asked for by the bench
	input  wire logic [1:0] pin_level,
	// pins toward the timers
	output var  logic [1:0] timer_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==================================================
	// pin driver
	// pins follow one edge late, as a synchronised source would
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_in <= 2'h0;
		end else begin
			timer_in <= pin_level;
		end
	end
endmodule : timer_pin_model
`default_nettype wire

// ### tb/timer_pwm_capture_core_tb.sv
// self-checking bench for the timer pair behind axi4-lite
`default_nettype none
`include "timer_defs.svh"
module timer_pwm_capture_core_tb import timer_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ==================================================
	// register byte addresses
	localparam logic [15:0] CH0  = {`TMR0_CMP_HIGH_IDX, 2'b00};
	localparam logic [15:0] CL0  = {`TMR0_CMP_LOW_IDX, 2'b00};
	localparam logic [15:0] CC0  = {`TMR0_CASC_CTRL_IDX, 2'b00};
	localparam logic [15:0] MC0  = {`TMR0_MAIN_CTRL_IDX, 2'b00};
	localparam logic [15:0] CNT0 = {`TMR0_COUNT_IDX, 2'b00};
	localparam logic [15:0] CH1  = {`TMR1_CMP_HIGH_IDX, 2'b00};
	localparam logic [15:0] CL1  = {`TMR1_CMP_LOW_IDX, 2'b00};
	localparam logic [15:0] CC1  = {`TMR1_CASC_CTRL_IDX, 2'b00};
	localparam logic [15:0] MC1  = {`TMR1_MAIN_CTRL_IDX, 2'b00};
	localparam logic [15:0] CNT1 = {`TMR1_COUNT_IDX, 2'b00};
	// one table row: address, write data, readback, response
	typedef struct packed {
		logic [15:0] a;
		logic [31:0] d;
		logic [31:0] e;
		logic [1:0]  r;
	} row_t;
	// ==================================================
	// signals
	logic        aclk      = 1'b0;
	logic        aresetn   = 1'b0;
	logic [15:0] awaddr    = 16'h0000;
	logic [15:0] araddr    = 16'h0000;
	logic [31:0] wdata     = 32'h0000_0000;
	logic        awvalid   = 1'b0;
	logic        wvalid    = 1'b0;
	logic        bready    = 1'b0;
	logic        arvalid   = 1'b0;
	logic        rready    = 1'b0;
	logic [3:0]  wstrb     = 4'hF;
	logic [2:0]  prot      = 3'h0;
	logic [1:0]  pin_level = 2'h0;
	wire  logic  awready, wready, bvalid, arready, rvalid;
	wire  logic [1:0]  bresp, rresp, timer_in, timer_out;
	wire  logic [31:0] rdata;
	int          num_errors = 0;
	int          tests_run  = 0;
	row_t        rows [9];
	// ==================================================
	// design and pin model
	timer_pwm_capture_core dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(prot),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(prot), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .timer_in(timer_in),
		.timer_out(timer_out)
	);
	timer_pin_model pins (
		.aclk(aclk), .aresetn(aresetn),
		.pin_level(pin_level), .timer_in(timer_in)
	);
	// 125 mhz clock
	always #4 aclk = ~aclk;
	// ==================================================
	// helpers
	function automatic logic [31:0] ctl(logic en, logic pol, op_mode_t m);
		return {24'h0, en, pol, 3'h0, m};
	endfunction : ctl
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [15:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 100);
		check({31'h0, bvalid}, 32'h1);
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 100);
		check({31'h0, rvalid}, 32'h1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	// write, then let the output settle for two edges
	task automatic cfg(input logic [15:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		repeat (2) @(posedge aclk);
	endtask : cfg
	// bounded wait for one output pin to reach a level
	task automatic wait_out(input int b, input logic lv, input int lim);
		int n;
		for (n = 0; n < lim && timer_out[b] !== lv; n++) @(posedge aclk);
		check({31'h0, timer_out[b]}, {31'h0, lv});
	endtask : wait_out
	task automatic end_sim();
		$display("tests_run %0d num_errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim
	// watchdog sized above the full pwm period plus the bus traffic
	initial begin : watchdog
		#760000;
		num_errors++;
		end_sim();
	end
	// ==================================================
	// main sequence
	initial begin : main_seq
		logic [31:0] v, w;
		logic [15:0] cap;
		logic [1:0]  r;
		rows = '{'{CH0, 32'hA5, 32'hA5, 2'h0}, '{CL0, 32'h5A, 32'h5A, 2'h0},
			'{CC0, 32'h10, 32'h10, 2'h0}, '{CH1, 32'h3C, 32'h3C, 2'h0},
			'{CL1, 32'hC3, 32'hC3, 2'h0}, '{CC1, 32'h00, 32'h00, 2'h0},
			'{MC1, 32'h3D, 32'h3D, 2'h0}, '{CNT0, 32'hFFFF, 32'h0, 2'h0},
			'{16'h0100, 32'h77, 32'h0, 2'h2}};
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check({30'h0, timer_out}, 32'h0);
		// reset value, write, readback for each row
		foreach (rows[i]) begin
			rd(rows[i].a, v, r);
			check(v, 32'h0);
			check({30'h0, r}, {30'h0, rows[i].r});
			wr(rows[i].a, rows[i].d, r);
			check({30'h0, r}, {30'h0, rows[i].r});
			rd(rows[i].a, v, r);
			check(v, rows[i].e);
		end
		// idle output levels while disabled
		cfg(MC0, ctl(1'b0, 1'b1, MODE_ONE_SHOT));
		check({31'h0, timer_out[0]}, 32'h1);
		cfg(MC0, ctl(1'b0, 1'b1, MODE_PWM));
		check({31'h0, timer_out[0]}, 32'h1);
		cfg(MC0, ctl(1'b0, 1'b0, MODE_PWM));
		check({31'h0, timer_out[0]}, 32'h0);
		// pwm: high at match 0x0040, low again at reload
		cfg(CH0, 32'h00);
		cfg(CL0, 32'h40);
		// timer one free-runs alongside and reloads just before
		cfg(MC1, ctl(1'b1, 1'b0, MODE_CONTINUOUS));
		cfg(MC0, ctl(1'b1, 1'b0, MODE_PWM));
		rd(CNT0, v, r);
		rd(CNT0, w, r);
		check({31'h0, v !== w}, 32'h1);
		wait_out(0, 1'b1, 300);
		rd(CNT0, v, r);
		check({31'h0, v >= 32'h40 && v < 32'h60}, 32'h1);
		wait_out(0, 1'b0, 70000);
		rd(CNT0, v, r);
		check({31'h0, v < 32'h20}, 32'h1);
		check({31'h0, timer_out[1]}, 32'h1);
		cfg(MC0, ctl(1'b0, 1'b0, MODE_PWM));
		check({31'h0, timer_out[0]}, 32'h0);
		rd(CNT0, v, r);
		rd(CNT0, w, r);
		check(w, v);
		// capture on rising edge only
		cfg(CH1, 32'h00);
		cfg(CL1, 32'h00);
		cfg(MC1, ctl(1'b1, 1'b0, MODE_CAPTURE));
		pin_level[1] <= 1'b1;
		repeat (5) @(posedge aclk);
		rd(CH1, v, r);
		rd(CL1, w, r);
		cap = {v[7:0], w[7:0]};
		check({31'h0, cap != 16'h0}, 32'h1);
		rd(CNT1, v, r);
		check({31'h0, v[15:0] > cap}, 32'h1);
		cfg(CH1, 32'h00);
		cfg(CL1, 32'h00);
		pin_level[1] <= 1'b0;
		repeat (5) @(posedge aclk);
		rd(CH1, v, r);
		rd(CL1, w, r);
		check({16'h0, v[7:0], w[7:0]}, 32'h0);
		// polarity one: rising edge ignored, falling edge captures
		cfg(MC1, ctl(1'b1, 1'b1, MODE_CAPTURE));
		pin_level[1] <= 1'b1;
		repeat (5) @(posedge aclk);
		rd(CH1, v, r);
		rd(CL1, w, r);
		check({16'h0, v[7:0], w[7:0]}, 32'h1 - 32'h1);
		pin_level[1] <= 1'b0;
		repeat (5) @(posedge aclk);
		rd(CH1, v, r);
		rd(CL1, w, r);
		check({31'h0, {v[7:0], w[7:0]} != 16'h0}, 32'h1);
		// counter on own pin, then cascaded from timer one output
		cfg(MC1, ctl(1'b0, 1'b0, MODE_ONE_SHOT));
		cfg(CC0, 32'h00);
		cfg(MC0, ctl(1'b1, 1'b0, MODE_COUNTER));
		rd(CNT0, v, r);
		pin_level[0] <= 1'b1;
		repeat (5) @(posedge aclk);
		pin_level[0] <= 1'b0;
		repeat (5) @(posedge aclk);
		rd(CNT0, w, r);
		check(w, v + 32'h1);
		cfg(CC0, 32'h10);
		pin_level[0] <= 1'b1;
		repeat (5) @(posedge aclk);
		cfg(MC1, ctl(1'b0, 1'b1, MODE_ONE_SHOT));
		check({31'h0, timer_out[1]}, 32'h1);
		rd(CNT0, w, r);
		check(w, v + 32'h2);
		// polarity one counts the partner output falling
		cfg(MC0, ctl(1'b1, 1'b1, MODE_COUNTER));
		cfg(MC1, ctl(1'b0, 1'b0, MODE_ONE_SHOT));
		rd(CNT0, w, r);
		check(w, v + 32'h3);
		end_sim();
	end
endmodule : timer_pwm_capture_core_tb
`default_nettype wire
